// File: design/elcr_defs.svh
// register indices, field positions, reset values of the echo limiter configuration bank
`ifndef ELCR_DEFS_SVH
`define ELCR_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define ELCR_IDX_FW_REV 6'h03
`define ELCR_IDX_ASH 6'h1d
`define ELCR_IDX_RL1 6'h24
`define ELCR_IDX_RL2 6'h25
`define ELCR_IDX_SL 6'h26
`define ELCR_IDX_CTRL 6'h30

// reset values
`define ELCR_ASH_RESET 8'h08
`define ELCR_RL1_RESET 8'h80
`define ELCR_RL2_RESET 8'h3e
`define ELCR_SL_RESET 8'h3d
`define ELCR_CTRL_RESET 8'h00
`define ELCR_RX_LIMIT_RESET 16'h1f40

// field positions
`define ELCR_RL1_BIT 7
`define ELCR_SL_MSB 7
`define ELCR_SL_LSB 3
`define ELCR_FW_LSB 5
`define ELCR_CTRL_USC_BIT 0
`define ELCR_RX_SHIFT 6
`define ELCR_ASH_MAX 8'h7f

`endif

// File: design/elcr_pkg.sv
// types shared by the echo limiter configuration bank
package elcr_pkg;

  typedef enum logic [1:0] {
    ELCR_RESP_OKAY = 2'h0,
    ELCR_RESP_SLVERR = 2'h2
  } elcr_resp_t;

  typedef logic [5:0] elcr_idx_t;

endpackage : elcr_pkg

// File: design/elcr_config_regs.sv
// echo limiter configuration register bank with an AXI4-Lite slave port
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "elcr_defs.svh"

module elcr_config_regs #(
  // arbitrary revision value
  parameter logic [2:0] FW_REVISION = 3'h2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // adaptation engine
  input wire logic [15:0] line_adapt_speed_i,
  input wire logic line_adapt_update_i,
  output logic [7:0] line_adapt_speed_high_o,
  output logic user_speed_control_o,
  // limiter thresholds
  output logic [15:0] receive_limit_o,
  output logic [4:0] send_limit_threshold_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic idx_known(input elcr_pkg::elcr_idx_t idx);
    idx_known = (idx == `ELCR_IDX_FW_REV) || (idx == `ELCR_IDX_ASH) || (idx == `ELCR_IDX_RL1) ||
                (idx == `ELCR_IDX_RL2) || (idx == `ELCR_IDX_SL) || (idx == `ELCR_IDX_CTRL);
  endfunction : idx_known

  // saturate an unsigned speed byte into the positive seven-bit range
  function automatic logic [7:0] clamp_speed(input logic [7:0] b);
    clamp_speed = b[7] ? `ELCR_ASH_MAX : b;
  endfunction : clamp_speed

  ////////////////////////////////////////////////////////////////////////////////
  // storage

  logic [7:0] ash_reg, ash_next;
  logic rl1_reg, rl1_next;
  logic [7:0] rl2_reg, rl2_next;
  logic [4:0] sl_reg, sl_next;
  logic usc_reg, usc_next;

  // reset words kept whole so each field is sliced out at its own width
  localparam logic [7:0] RL1_RESET = `ELCR_RL1_RESET;
  localparam logic [7:0] SL_RESET = `ELCR_SL_RESET;
  localparam logic [7:0] CTRL_RESET = `ELCR_CTRL_RESET;

  logic aw_held_reg, aw_held_next;
  elcr_pkg::elcr_idx_t aw_idx_reg, aw_idx_next;
  logic w_held_reg, w_held_next;
  logic [7:0] w_data_reg, w_data_next;
  logic w_lane0_reg, w_lane0_next;
  logic bvalid_reg, bvalid_next;
  elcr_pkg::elcr_resp_t bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  elcr_pkg::elcr_resp_t rresp_reg, rresp_next;

  logic do_write;
  logic write_ok;
  elcr_pkg::elcr_idx_t ar_idx;

  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign ar_idx = s_axi_araddr_i[7:2];
  // the speed byte only accepts software writes once software owns it
  assign write_ok = idx_known(aw_idx_reg) && (aw_idx_reg != `ELCR_IDX_FW_REV) &&
                    ((aw_idx_reg != `ELCR_IDX_ASH) || usc_reg);

  assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_idx_next = aw_idx_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_lane0_next = w_lane0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_next = 1'b1;
      aw_idx_next = s_axi_awaddr_i[7:2];
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata_i[7:0];
      w_lane0_next = s_axi_wstrb_i[0];
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = write_ok ? elcr_pkg::ELCR_RESP_OKAY : elcr_pkg::ELCR_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_next = 1'b1;
      rresp_next = idx_known(ar_idx) ? elcr_pkg::ELCR_RESP_OKAY : elcr_pkg::ELCR_RESP_SLVERR;
      rdata_next = 32'h0000_0000;
      unique case (ar_idx)
        `ELCR_IDX_FW_REV: rdata_next[7:`ELCR_FW_LSB] = FW_REVISION;
        `ELCR_IDX_ASH: rdata_next[7:0] = ash_reg;
        `ELCR_IDX_RL1: rdata_next[`ELCR_RL1_BIT] = rl1_reg;
        `ELCR_IDX_RL2: rdata_next[7:0] = rl2_reg;
        `ELCR_IDX_SL: rdata_next[7:0] = {sl_reg, SL_RESET[`ELCR_SL_LSB-1:0]};
        `ELCR_IDX_CTRL: rdata_next[`ELCR_CTRL_USC_BIT] = usc_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= elcr_pkg::ELCR_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= elcr_pkg::ELCR_RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_idx_reg <= aw_idx_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_lane0_reg <= w_lane0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_comb begin
    ash_next = ash_reg;
    rl1_next = rl1_reg;
    rl2_next = rl2_reg;
    sl_next = sl_reg;
    usc_next = usc_reg;
    // hardware tracks the speed until software claims it
    if (!usc_reg && line_adapt_update_i) begin
      ash_next = clamp_speed(line_adapt_speed_i[15:8]);
    end
    if (do_write && write_ok && w_lane0_reg) begin
      unique case (aw_idx_reg)
        `ELCR_IDX_ASH: ash_next = clamp_speed(w_data_reg);
        `ELCR_IDX_RL1: rl1_next = w_data_reg[`ELCR_RL1_BIT];
        `ELCR_IDX_RL2: rl2_next = w_data_reg;
        `ELCR_IDX_SL: sl_next = w_data_reg[`ELCR_SL_MSB:`ELCR_SL_LSB];
        `ELCR_IDX_CTRL: usc_next = w_data_reg[`ELCR_CTRL_USC_BIT];
        default: usc_next = usc_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ash_reg <= `ELCR_ASH_RESET;
      rl1_reg <= RL1_RESET[`ELCR_RL1_BIT];
      rl2_reg <= `ELCR_RL2_RESET;
      sl_reg <= SL_RESET[`ELCR_SL_MSB:`ELCR_SL_LSB];
      usc_reg <= CTRL_RESET[`ELCR_CTRL_USC_BIT];
    end else begin
      ash_reg <= ash_next;
      rl1_reg <= rl1_next;
      rl2_reg <= rl2_next;
      sl_reg <= sl_next;
      usc_reg <= usc_next;
    end
  end

  assign line_adapt_speed_high_o = ash_reg;
  assign user_speed_control_o = usc_reg;
  assign receive_limit_o = {1'b0, rl2_reg, rl1_reg, 6'h00};
  assign send_limit_threshold_o = sl_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_ash_reset;
    $past(reset_i) |-> (ash_reg == 8'h08);
  endproperty
  a_ash_reset: assert property (p_ash_reset) else $error("speed byte not 08h after reset");

  property p_speed_range;
    line_adapt_speed_high_o[7] == 1'b0;
  endproperty
  a_speed_range: assert property (p_speed_range) else $error("speed outside positive range");

  property p_hw_update;
    (!usc_reg && line_adapt_update_i && !(do_write && aw_idx_reg == `ELCR_IDX_ASH))
      |=> (ash_reg == clamp_speed($past(line_adapt_speed_i[15:8])));
  endproperty
  a_hw_update: assert property (p_hw_update) else $error("hardware speed update lost");

  property p_user_hold;
    (usc_reg && !do_write) |=> $stable(ash_reg);
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("speed moved under user control");

  property p_rl2_write;
    (do_write && write_ok && w_lane0_reg && aw_idx_reg == `ELCR_IDX_RL2)
      |=> (receive_limit_o[14:7] == $past(w_data_reg)) && s_axi_bvalid_o;
  endproperty
  a_rl2_write: assert property (p_rl2_write) else $error("upper limit bits not taken");

  property p_rl1_write;
    (do_write && write_ok && w_lane0_reg && aw_idx_reg == `ELCR_IDX_RL1)
      |=> (receive_limit_o[6] == $past(w_data_reg[`ELCR_RL1_BIT]));
  endproperty
  a_rl1_write: assert property (p_rl1_write) else $error("lowest limit bit not taken");

  property p_ash_refused;
    (do_write && !usc_reg && aw_idx_reg == `ELCR_IDX_ASH)
      |=> s_axi_bvalid_o && (s_axi_bresp_o == elcr_pkg::ELCR_RESP_SLVERR);
  endproperty
  a_ash_refused: assert property (p_ash_refused) else $error("speed write accepted without user control");

  property p_rx_reset;
    $past(reset_i) |-> (receive_limit_o == 16'h1f40);
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("receive limit default wrong");

  property p_rx_shift;
    receive_limit_o[5:0] == 6'h00 && receive_limit_o[15] == 1'b0;
  endproperty
  a_rx_shift: assert property (p_rx_shift) else $error("receive limit low bits not zero");

  property p_sl_write;
    (do_write && write_ok && w_lane0_reg && aw_idx_reg == `ELCR_IDX_SL)
      |=> (send_limit_threshold_o == $past(w_data_reg[7:3]));
  endproperty
  a_sl_write: assert property (p_sl_write) else $error("send limit not taken");

  property p_fw_read;
    (s_axi_arvalid_i && s_axi_arready_o && ar_idx == `ELCR_IDX_FW_REV)
      |=> s_axi_rvalid_o && (s_axi_rdata_o == {24'h00_0000, FW_REVISION, 5'h00});
  endproperty
  a_fw_read: assert property (p_fw_read) else $error("revision read wrong");

endmodule : elcr_config_regs

// File: verif/test_elcr_config_regs.sv
// self-checking testbench for the echo limiter configuration register bank
`timescale 1ns/1ps
`include "elcr_defs.svh"

module test_elcr_config_regs;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, usc;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] speed = 16'h0000;
  logic upd = 1'b0;
  logic [7:0] speed_high;
  logic [15:0] rx_limit;
  logic [4:0] tx_limit;
  int error_cnt = 0, total_checks = 0, cycle_cnt = 0;
  logic [8:0] fields [3] = '{9'h001, 9'h1ff, 9'h0a5};

  always #5 clk_i = ~clk_i;

  elcr_config_regs DUT (
    .clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .line_adapt_speed_i(speed), .line_adapt_update_i(upd),
    .line_adapt_speed_high_o(speed_high), .user_speed_control_o(usc),
    .receive_limit_o(rx_limit), .send_limit_threshold_o(tx_limit)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // handshake values are read in the edge's active region, before the design's updates land
  task automatic axi_write(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_i);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        check({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [5:0] idx, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clk_i);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        check(rdata, {24'h00_0000, ed});
        check({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read

  task automatic hw_update(input logic [15:0] v, input logic [7:0] exp);
    @(posedge clk_i);
    speed <= v;
    upd <= 1'b1;
    @(posedge clk_i);
    upd <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 check({24'h00_0000, speed_high}, {24'h00_0000, exp});
  endtask : hw_update

  //////////////////////////////////////////////////////////////////////////////
  // a hung handshake stops the run here
  always @(posedge clk_i) begin
    cycle_cnt++;
    if (cycle_cnt == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    axi_read(`ELCR_IDX_FW_REV, 8'h40, 2'h0);
    axi_read(`ELCR_IDX_ASH, 8'h08, 2'h0);
    axi_read(`ELCR_IDX_RL1, 8'h80, 2'h0);
    axi_read(`ELCR_IDX_RL2, 8'h3e, 2'h0);
    axi_read(`ELCR_IDX_SL, 8'h3d, 2'h0);
    check({16'h0000, rx_limit}, 32'h0000_1f40);
    check({27'h0, tx_limit}, 32'h0000_0007);
    check({24'h00_0000, speed_high}, 32'h0000_0008);
    // the revision register refuses writes and keeps its value
    axi_write(`ELCR_IDX_FW_REV, 8'hff, 2'h2);
    axi_read(`ELCR_IDX_FW_REV, 8'h40, 2'h0);
    // hardware owns the speed byte until software claims it
    axi_write(`ELCR_IDX_ASH, 8'h11, 2'h2);
    hw_update(16'h5a12, 8'h5a);
    hw_update(16'h9000, 8'h7f);
    axi_read(`ELCR_IDX_ASH, 8'h7f, 2'h0);
    axi_write(`ELCR_IDX_CTRL, 8'h01, 2'h0);
    check({31'h0, usc}, 32'h0000_0001);
    hw_update(16'h1234, 8'h7f);
    axi_write(`ELCR_IDX_ASH, 8'h33, 2'h0);
    axi_read(`ELCR_IDX_ASH, 8'h33, 2'h0);
    axi_write(`ELCR_IDX_ASH, 8'hff, 2'h0);
    axi_read(`ELCR_IDX_ASH, 8'h7f, 2'h0);
    // limits one above the low end (001h), at the top end (1FFh) and one value between
    foreach (fields[i]) begin
      axi_write(`ELCR_IDX_RL1, {fields[i][0], 7'h7f}, 2'h0);
      axi_write(`ELCR_IDX_RL2, fields[i][8:1], 2'h0);
      check({16'h0000, rx_limit}, {16'h0000, 1'b0, fields[i], 6'h00});
      axi_read(`ELCR_IDX_RL1, {fields[i][0], 7'h00}, 2'h0);
      axi_read(`ELCR_IDX_RL2, fields[i][8:1], 2'h0);
    end
    axi_write(`ELCR_IDX_SL, 8'hf8, 2'h0);
    check({27'h0, tx_limit}, 32'h0000_001f);
    axi_read(`ELCR_IDX_SL, 8'hfd, 2'h0);
    axi_write(`ELCR_IDX_SL, 8'h02, 2'h0);
    check({27'h0, tx_limit}, 32'h0000_0000);
    axi_read(`ELCR_IDX_SL, 8'h05, 2'h0);
    // a write with its low lane disabled is answered but stores nothing
    wstrb <= 4'h0;
    axi_write(`ELCR_IDX_RL2, 8'h00, 2'h0);
    axi_read(`ELCR_IDX_RL2, fields[2][8:1], 2'h0);
    wstrb <= 4'hf;
    // unmapped word is refused both ways
    axi_write(6'h0f, 8'h55, 2'h2);
    axi_read(6'h0f, 8'h00, 2'h2);
    // a second reset in mid-run brings back every power-up value
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    axi_read(`ELCR_IDX_RL2, 8'h3e, 2'h0);
    check({16'h0000, rx_limit}, 32'h0000_1f40);
    check({27'h0, tx_limit}, 32'h0000_0007);
    check({24'h00_0000, speed_high}, 32'h0000_0008);
    check({31'h0, usc}, 32'h0000_0000);
    report_and_stop();
  end
endmodule : test_elcr_config_regs
